// [rtl/fsu_top.sv]
// Sector erase and unsecure command sequencer with register port
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fsu_top
	import fsu_pkg::*;
#(
	parameter int          SECT_WORDS   = 4,
	parameter int          PF_SECTORS   = 8,
	parameter int          DF_WORDS     = 16,
	parameter int          SECT_SHIFT   = 10,
	parameter logic [6:0]  PF_BLK_LO    = 7'h70
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              srst,
	// Register port
	input  wire logic [REG_AW-1:0] reg_addr,
	input  wire logic [REG_DW-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [REG_DW-1:0] reg_rdata,
	// Array feedback during erase and verify
	input  wire logic              ecc_corr,
	input  wire logic              ecc_uncorr,
	input  wire logic              erase_inhibit,
	// Status outputs
	output logic                   secure,
	output logic                   busy,
	output logic                   irq
);
	localparam int DEPTH = PF_SECTORS * SECT_WORDS + DF_WORDS;
	localparam int AW    = $clog2(DEPTH);
	localparam int SW    = $clog2(PF_SECTORS);

	if (SECT_WORDS < 1 || PF_SECTORS < 2 || PF_SECTORS > REG_DW || DF_WORDS < 1
	    || SECT_SHIFT < 3 || SECT_SHIFT + SW > 16) begin : g_chk
		$error("fsu_top: unsupported geometry parameters");
	end

	typedef enum logic [2:0] {S_IDLE, S_ERASE, S_VRD, S_VCK, S_DONE} fsu_state_t;

	fsu_bus_t bus;
	assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	fsu_state_t        state_q, state_d;
	fsu_status_t       st_q;
	logic [2:0]        idx_q;
	logic [15:0]       word_q [8];
	logic [2:0]        cfg_q;
	logic [PF_SECTORS-1:0] prot_q;
	logic [2:0]        irq_st_q, irq_en_q;
	logic              secure_q;
	logic [AW-1:0]     prog_addr_q;
	logic [AW-1:0]     ptr_q, hi_q;
	logic              unsec_q;
	logic              fail_q;
	logic [REG_DW-1:0] rdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// Decode
	wire wr_status = bus.wr && bus.addr == REG_STATUS;
	wire wr_index  = bus.wr && bus.addr == REG_CMD_INDEX;
	wire wr_word   = bus.wr && bus.addr == REG_CMD_WORD;
	wire wr_cfg    = bus.wr && bus.addr == REG_CONFIG;
	wire wr_prot   = bus.wr && bus.addr == REG_PROT;
	wire wr_irq_en = bus.wr && bus.addr == REG_IRQ_EN;
	wire wr_irq_cl = bus.wr && bus.addr == REG_IRQ_CLR;
	wire wr_paddr  = bus.wr && bus.addr == REG_PROG_ADDR;
	wire wr_pdata  = bus.wr && bus.addr == REG_PROG_DATA;
	wire idle      = state_q == S_IDLE;

	// Launch needs completion set and both error flags already cleared
	wire launch = wr_status && bus.wdata[ST_COMMAND_COMPLETE_FLAG] && st_q.command_complete_flag
	              && !st_q.access_error_flag && !st_q.protection_violation_flag;

	wire [7:0]  cmd_code = word_q[0][15:8];
	wire [6:0]  blk_sel  = word_q[0][6:0];
	wire [15:0] addr_lo  = word_q[1];
	wire [SW-1:0] sect   = addr_lo[SECT_SHIFT +: SW];
	wire is_sector  = cmd_code == CMD_ERASE_SECTOR;
	wire is_unsec   = cmd_code == CMD_UNSECURE;

	wire bad_index  = idx_q != IDX_ERASE_SECTOR;
	wire bad_ldf    = cfg_q[CFG_LDF_ACT];
	wire bad_blk    = blk_sel < PF_BLK_LO;
	wire bad_align  = addr_lo[2:0] != 3'h0;
	wire bad_mode   = is_sector ? !cfg_q[CFG_SECT_OK] : !cfg_q[CFG_UNSEC_OK];

	wire sect_acc   = bad_index || bad_ldf || bad_mode || bad_blk || bad_align;
	wire acc_err    = is_sector ? sect_acc : (is_unsec ? bad_mode : 1'b1);
	wire prot_err   = is_sector && !acc_err && prot_q[sect];
	wire launch_err = acc_err || prot_err;

	wire [AW-1:0] sect_base = AW'(int'(sect) * SECT_WORDS);
	wire [AW-1:0] sect_last = AW'(int'(sect) * SECT_WORDS + SECT_WORDS - 1);
	wire [AW-1:0] all_last  = AW'(DEPTH - 1);

	////////////////////////////////////////////////////////////////////////////////
	// Array
	wire [15:0]   arr_rdata;
	wire          vfy_bad   = arr_rdata != ERASED_WORD || ecc_corr || ecc_uncorr;
	wire          erase_we  = state_q == S_ERASE && !erase_inhibit;
	wire          arr_we    = erase_we || (wr_pdata && idle);
	wire [AW-1:0] arr_waddr = idle ? prog_addr_q : ptr_q;
	wire [15:0]   arr_wdata = idle ? bus.wdata : ERASED_WORD;
	wire          at_end    = ptr_q == hi_q;
	wire          finish    = state_q == S_VCK && at_end;

	fsu_array #(
		.DW    (16),
		.DEPTH (DEPTH)
	) u_array (
		.clk     (core_clk),
		.we      (arr_we),
		.waddr   (arr_waddr),
		.wdata   (arr_wdata),
		.raddr   (ptr_q),
		.rdata_q (arr_rdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			S_IDLE: begin
				if (launch && !launch_err) begin
					state_d = S_ERASE;
				end
			end
			S_ERASE: begin
				if (at_end) begin
					state_d = S_VRD;
				end
			end
			S_VRD:   state_d = S_VCK;
			S_VCK:   state_d = at_end ? S_DONE : S_VRD;
			S_DONE:  state_d = S_IDLE;
			default: state_d = S_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_q <= S_IDLE;
			ptr_q   <= '0;
			hi_q    <= '0;
			unsec_q <= 1'b0;
			fail_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			if (idle && launch && !launch_err) begin
				ptr_q   <= is_unsec ? '0 : sect_base;
				hi_q    <= is_unsec ? all_last : sect_last;
				unsec_q <= is_unsec;
				fail_q  <= 1'b0;
			end else if (state_q == S_ERASE) begin
				ptr_q <= at_end ? (unsec_q ? '0 : hi_q - AW'(SECT_WORDS - 1)) : ptr_q + 1'b1;
			end else if (state_q == S_VCK) begin
				ptr_q  <= at_end ? ptr_q : ptr_q + 1'b1;
				fail_q <= fail_q || vfy_bad;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status flags
	wire done_now  = state_q == S_DONE || (idle && launch && launch_err);
	wire verr_hit  = state_q == S_VCK && vfy_bad;
	wire vunc_hit  = state_q == S_VCK && ecc_uncorr;
	wire clr_err   = wr_status && idle;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_q <= STATUS_RESET;
		end else begin
			if (done_now) begin
				st_q.command_complete_flag <= 1'b1;
			end else if (launch && !launch_err) begin
				st_q.command_complete_flag <= 1'b0;
			end
			if (idle && launch) begin
				st_q.verr <= 1'b0;
				st_q.vunc <= 1'b0;
			end else begin
				st_q.verr <= st_q.verr || verr_hit;
				st_q.vunc <= st_q.vunc || vunc_hit;
			end
			// Set wins over a write-one clear in the same cycle
			st_q.access_error_flag <= (idle && launch && acc_err)
			               || (st_q.access_error_flag && !(clr_err && bus.wdata[ST_ACCESS_ERROR_FLAG]));
			st_q.protection_violation_flag <= (idle && launch && prot_err)
			               || (st_q.protection_violation_flag && !(clr_err && bus.wdata[ST_PROTECTION_VIOLATION_FLAG]));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Security
	always_ff @(posedge core_clk) begin
		if (srst) begin
			secure_q <= SECURE_RESET;
		end else if (finish && unsec_q && !fail_q && !vfy_bad) begin
			secure_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Software registers
	always_ff @(posedge core_clk) begin
		if (srst) begin
			idx_q       <= 3'h0;
			cfg_q       <= CFG_RESET;
			prot_q      <= '0;
			irq_en_q    <= 3'h0;
			prog_addr_q <= '0;
			for (int i = 0; i < 8; i++) begin
				word_q[i] <= 16'h0000;
			end
		end else begin
			// Command words stay frozen while a command runs
			if (wr_index && st_q.command_complete_flag) begin
				idx_q <= bus.wdata[2:0];
			end
			if (wr_word && st_q.command_complete_flag) begin
				word_q[idx_q] <= bus.wdata;
			end
			if (wr_cfg) begin
				cfg_q <= bus.wdata[2:0];
			end
			if (wr_prot) begin
				prot_q <= bus.wdata[PF_SECTORS-1:0];
			end
			if (wr_irq_en) begin
				irq_en_q <= bus.wdata[2:0];
			end
			if (wr_paddr) begin
				prog_addr_q <= bus.wdata[AW-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupts
	logic [2:0] irq_set;
	assign irq_set[IRQ_DONE] = done_now;
	assign irq_set[IRQ_ERR]  = idle && launch && launch_err;
	assign irq_set[IRQ_VFY]  = verr_hit;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			irq_st_q <= 3'h0;
		end else begin
			irq_st_q <= irq_set | (irq_st_q & ~(wr_irq_cl ? bus.wdata[2:0] : 3'h0));
		end
	end

	assign irq = |(irq_st_q & irq_en_q);

	////////////////////////////////////////////////////////////////////////////////
	// Read back
	wire [REG_DW-1:0] st_word = REG_DW'({st_q.command_complete_flag, 1'b0, st_q.access_error_flag, st_q.protection_violation_flag,
	                                     2'b00, st_q.verr, st_q.vunc});
	logic [REG_DW-1:0] rsel;

	always_comb begin
		rsel = '0;
		case (bus.addr)
			REG_STATUS:    rsel = st_word;
			REG_CMD_INDEX: rsel = REG_DW'(idx_q);
			REG_CMD_WORD:  rsel = word_q[idx_q];
			REG_CONFIG:    rsel = REG_DW'(cfg_q);
			REG_PROT:      rsel = REG_DW'(prot_q);
			REG_IRQ_STAT:  rsel = REG_DW'(irq_st_q);
			REG_IRQ_EN:    rsel = REG_DW'(irq_en_q);
			REG_SECURITY:  rsel = REG_DW'(secure_q);
			REG_PROG_ADDR: rsel = REG_DW'(prog_addr_q);
			default:       rsel = '0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= bus.rd ? rsel : '0;
		end
	end

	assign reg_rdata = rdata_q;
	assign secure    = secure_q;
	assign busy      = !idle;

endmodule : fsu_top
`default_nettype wire

// [rtl/fsu_pkg.sv]
// Constants, types and register map of the flash sector erase / unsecure sequencer
// Summary of operation
// - Launch erases every address of the sector, then verifies it erased.
// - Completion flag sets again only after erase and verify finish.
// - Access error if command word index is not 001 at launch.
// - Access error if a load-data-field sequence is still active.
// - Access error if sector erase is not allowed in current mode.
// - Access error if address bits 22..16 select no valid block.
// - Access error if address bits 2..0 are not all zero.
// - Protection violation if the targeted sector is protected.
// - Verify error flag sets on any verify error, correctable or not.
// - Uncorrectable verify flag sets on a non-correctable verify error.
// - Unsecure erases the whole program and data flash, then verifies it.
// - Security is released only when that verify passes.
// - Failed unsecure verify sets verify error flag, security unchanged.
package fsu_pkg;

	localparam int          REG_AW = 4;
	localparam int          REG_DW = 16;

	// Register offsets
	localparam logic [3:0]  REG_STATUS    = 4'h0;
	localparam logic [3:0]  REG_CMD_INDEX = 4'h1;
	localparam logic [3:0]  REG_CMD_WORD  = 4'h2;
	localparam logic [3:0]  REG_CONFIG    = 4'h3;
	localparam logic [3:0]  REG_PROT      = 4'h4;
	localparam logic [3:0]  REG_IRQ_STAT  = 4'h5;
	localparam logic [3:0]  REG_IRQ_EN    = 4'h6;
	localparam logic [3:0]  REG_IRQ_CLR   = 4'h7;
	localparam logic [3:0]  REG_SECURITY  = 4'h8;
	localparam logic [3:0]  REG_PROG_ADDR = 4'h9;
	localparam logic [3:0]  REG_PROG_DATA = 4'hA;

	// Status field positions
	localparam int          ST_COMMAND_COMPLETE_FLAG   = 7;
	localparam int          ST_ACCESS_ERROR_FLAG = 5;
	localparam int          ST_PROTECTION_VIOLATION_FLAG = 4;
	localparam int          ST_VERR   = 1;
	localparam int          ST_VUNC   = 0;

	// Config field positions and reset value
	localparam int          CFG_SECT_OK  = 0;
	localparam int          CFG_UNSEC_OK = 1;
	localparam int          CFG_LDF_ACT  = 2;
	localparam logic [2:0]  CFG_RESET    = 3'h3;

	// Interrupt field positions
	localparam int          IRQ_DONE = 0;
	localparam int          IRQ_ERR  = 1;
	localparam int          IRQ_VFY  = 2;

	// Command codes and indexes
	localparam logic [7:0]  CMD_ERASE_SECTOR = 8'h0A;
	localparam logic [7:0]  CMD_UNSECURE     = 8'h0B;
	localparam logic [2:0]  IDX_ERASE_SECTOR = 3'h1;
	localparam logic [15:0] ERASED_WORD      = 16'hFFFF;
	localparam logic        SECURE_RESET     = 1'b1;

	typedef struct packed {
		logic command_complete_flag;
		logic access_error_flag;
		logic protection_violation_flag;
		logic verr;
		logic vunc;
	} fsu_status_t;

	localparam fsu_status_t STATUS_RESET = '{command_complete_flag: 1'b1, default: 1'b0};

	typedef struct packed {
		logic [REG_AW-1:0] addr;
		logic [REG_DW-1:0] wdata;
		logic              wr;
		logic              rd;
	} fsu_bus_t;

endpackage : fsu_pkg

// [rtl/fsu_array.sv]
// Flash array model: one write port, registered read data
`timescale 1ns/1ps
`default_nettype none
module fsu_array #(
	parameter int DW    = 16,
	parameter int DEPTH = 48
) (
	// Clock
	input  wire logic                     clk,
	// Write port
	input  wire logic                     we,
	input  wire logic [$clog2(DEPTH)-1:0] waddr,
	input  wire logic [DW-1:0]            wdata,
	// Read port
	input  wire logic [$clog2(DEPTH)-1:0] raddr,
	output logic      [DW-1:0]            rdata_q
);
	logic [DW-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_q <= mem[raddr];
	end
endmodule : fsu_array
`default_nettype wire

// [tb/fsu_top_sva.sv]
// Port-level assertions for the sector erase and unsecure sequencer
`timescale 1ns/1ps
`default_nettype none
module fsu_top_sva
	import fsu_pkg::*;
(
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              srst,
	// Register port
	input  wire logic [REG_AW-1:0] reg_addr,
	input  wire logic [REG_DW-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [REG_DW-1:0] reg_rdata,
	// Status
	input  wire logic              secure,
	input  wire logic              busy,
	input  wire logic              irq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	wire st_rd     = reg_rd && (reg_addr == REG_STATUS);
	wire launch_wr = reg_wr && (reg_addr == REG_STATUS) && reg_wdata[ST_COMMAND_COMPLETE_FLAG];

	property p_rdata_idle;
		!$past(reg_rd) |-> reg_rdata == 16'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
	property p_command_complete_flag_busy;
		st_rd && busy |=> !reg_rdata[ST_COMMAND_COMPLETE_FLAG];
	endproperty
	a_command_complete_flag_busy: assert property (p_command_complete_flag_busy) else $error("done flag set while busy");
	property p_command_complete_flag_idle;
		st_rd && !busy |=> reg_rdata[ST_COMMAND_COMPLETE_FLAG];
	endproperty
	a_command_complete_flag_idle: assert property (p_command_complete_flag_idle) else $error("done flag low while idle");
	property p_sec_fall;
		$fell(secure) |-> $past(busy);
	endproperty
	a_sec_fall: assert property (p_sec_fall) else $error("security released when idle");
	property p_sec_rise;
		!$past(srst) |-> !$rose(secure);
	endproperty
	a_sec_rise: assert property (p_sec_rise) else $error("security set again");
	property p_busy_cause;
		$rose(busy) |-> $past(launch_wr);
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without launch");
	property p_busy_min;
		$rose(busy) |-> busy[*8];
	endproperty
	a_busy_min: assert property (p_busy_min) else $error("command ended too soon");
	property p_busy_max;
		$rose(busy) |-> ##[1:200] !busy;
	endproperty
	a_busy_max: assert property (p_busy_max) else $error("command never ended");
	property p_irq_rise;
		!$past(srst) && $rose(irq) |-> $past(reg_wr) || $past(busy);
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("interrupt without cause");
	property p_irq_fall;
		!$past(srst) && $fell(irq) |-> $past(reg_wr);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped by itself");
endmodule : fsu_top_sva

bind fsu_top fsu_top_sva u_fsu_top_sva (
	.core_clk  (core_clk),
	.srst      (srst),
	.reg_addr  (reg_addr),
	.reg_wdata (reg_wdata),
	.reg_wr    (reg_wr),
	.reg_rd    (reg_rd),
	.reg_rdata (reg_rdata),
	.secure    (secure),
	.busy      (busy),
	.irq       (irq)
);
`default_nettype wire

// [tb/tb_fsu_top.sv]
// Self-checking testbench for the sector erase and unsecure sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_fsu_top
	import fsu_pkg::*;
;
	logic              core_clk, srst, reg_wr, reg_rd;
	logic [REG_AW-1:0] reg_addr;
	logic [REG_DW-1:0] reg_wdata, reg_rdata, rd_val;
	logic              ecc_corr, ecc_uncorr, erase_inhibit, secure, busy, irq;
	int                num_errors, samples_checked;

	fsu_top u_fsu_top (
		.core_clk      (core_clk),
		.srst          (srst),
		.reg_addr      (reg_addr),
		.reg_wdata     (reg_wdata),
		.reg_wr        (reg_wr),
		.reg_rd        (reg_rd),
		.reg_rdata     (reg_rdata),
		.ecc_corr      (ecc_corr),
		.ecc_uncorr    (ecc_uncorr),
		.erase_inhibit (erase_inhibit),
		.secure        (secure),
		.busy          (busy),
		.irq           (irq)
	);

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rchk(input logic [3:0] a, input logic [15:0] exp, input string what);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		rd_val = reg_rdata;
		chk(rd_val, exp, what);
	endtask : rchk

	task automatic cmd(input logic [7:0] c, input logic [6:0] b, input logic [15:0] ad,
			input logic [2:0] idx);
		wr(REG_CMD_INDEX, 16'h0000);
		wr(REG_CMD_WORD, {c, 1'b0, b});
		wr(REG_CMD_INDEX, 16'h0001);
		wr(REG_CMD_WORD, ad);
		wr(REG_CMD_INDEX, {13'h0, idx});
	endtask : cmd

	// Busy cycles after launch, bounded so a stuck sequencer cannot hang the run
	task automatic launch(input int exp_n);
		int n;
		n = 0;
		wr(REG_STATUS, 16'h0080);
		// A good launch is read back once mid-command; the read costs three cycles
		if (exp_n > 0) begin
			rchk(REG_STATUS, 16'h0000, "status while busy");
			n = 3;
		end
		do begin
			@(posedge core_clk);
			n++;
		end while (busy === 1'b1 && n < 400);
		chk(16'(n - 1), 16'(exp_n), "busy length");
	endtask : launch

	task automatic fill_sector;
		for (int w = 8; w < 12; w++) begin
			wr(REG_PROG_ADDR, 16'(w));
			wr(REG_PROG_DATA, 16'h0000);
		end
	endtask : fill_sector

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rchk(REG_STATUS, 16'h0080, "reset status");
		rchk(REG_SECURITY, 16'h0001, "reset security");
		rchk(REG_CONFIG, 16'h0003, "reset config");
		rchk(4'hF, 16'h0000, "unmapped read");
		rchk(REG_IRQ_CLR, 16'h0000, "write-only read");
		chk({15'h0, irq}, 16'h0000, "reset irq");
		$display("test reset done");
	endtask : t_reset

	task automatic t_sector;
		wr(REG_IRQ_EN, 16'h0007);
		for (int k = 0; k < 4; k++) begin
			erase_inhibit <= (k == 1);
			ecc_corr      <= (k == 2);
			ecc_uncorr    <= (k == 3);
			fill_sector();
			cmd(CMD_ERASE_SECTOR, 7'h70, 16'h0800, 3'h1);
			launch(13);
			rchk(REG_STATUS, k == 0 ? 16'h0080 : k == 3 ? 16'h0083 : 16'h0082,
				"verify flags");
			chk({15'h0, irq}, 16'h0001, "done irq");
			wr(REG_IRQ_CLR, 16'h0007);
			// The pin follows the clear on the same edge that takes the write
			@(posedge core_clk);
			chk({15'h0, irq}, 16'h0000, "irq cleared");
		end
		erase_inhibit <= 1'b0;
		ecc_corr      <= 1'b0;
		ecc_uncorr    <= 1'b0;
		$display("test sector done");
	endtask : t_sector

	task automatic t_errors;
		// Last pass carries a command code that the sequencer does not know
		for (int i = 0; i < 8; i++) begin
			wr(REG_CONFIG, i == 1 ? 16'h0007 : i == 2 ? 16'h0002 : i == 6 ? 16'h0001 : 16'h0003);
			wr(REG_PROT, i == 5 ? 16'h0004 : 16'h0000);
			cmd(i == 6 ? CMD_UNSECURE : i == 7 ? 8'h00 : CMD_ERASE_SECTOR,
				i == 3 ? 7'h6F : 7'h70, i == 4 ? 16'h0804 : 16'h0800, i == 0 ? 3'h2 : 3'h1);
			launch(0);
			rchk(REG_STATUS, i == 5 ? 16'h0090 : 16'h00A0, "launch error");
			rchk(REG_IRQ_STAT, 16'h0003, "error irq status");
			wr(REG_IRQ_EN, 16'h0000);
			@(posedge core_clk);
			chk({15'h0, irq}, 16'h0000, "irq masked");
			wr(REG_IRQ_EN, 16'h0007);
			wr(REG_IRQ_CLR, 16'h0007);
			wr(REG_STATUS, 16'h0030);
			rchk(REG_STATUS, 16'h0080, "errors cleared");
		end
		wr(REG_CONFIG, 16'h0003);
		wr(REG_PROT, 16'h0000);
		$display("test errors done");
	endtask : t_errors

	task automatic t_unsecure;
		for (int k = 0; k < 2; k++) begin
			erase_inhibit <= (k == 0);
			wr(REG_PROG_ADDR, 16'h0000);
			wr(REG_PROG_DATA, 16'h0000);
			cmd(CMD_UNSECURE, 7'h00, 16'h0000, 3'h0);
			launch(145);
			rchk(REG_STATUS, k == 0 ? 16'h0082 : 16'h0080, "unsecure verify");
			rchk(REG_SECURITY, 16'(k == 0), "security register");
			chk({15'h0, secure}, 16'(k == 0), "secure pin");
		end
		$display("test unsecure done");
	endtask : t_unsecure

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		num_errors++;
		$display("BAD %0t watchdog expired", $time);
		report_and_stop();
	end

	initial begin
		srst          = 1'b1;
		reg_wr        = 1'b0;
		reg_rd        = 1'b0;
		reg_addr      = 4'h0;
		reg_wdata     = 16'h0000;
		ecc_corr      = 1'b0;
		ecc_uncorr    = 1'b0;
		erase_inhibit = 1'b0;
		num_errors    = 0;
		samples_checked = 0;
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		t_reset();
		t_sector();
		t_errors();
		t_unsecure();
		report_and_stop();
	end
endmodule : tb_fsu_top
`default_nettype wire
